// *** bench/tb_top.sv ***
// Self-checking bench for the supervision timer.
`timescale 1ns/10ps
module tb_top;
  import wdsup_pkg::*;
  logic                  sys_clk, rstn, enable, kick_pin_en, kick_input, kick_cmd, kreq, kpin;
  logic                  timeout_pin_en, reset_on_expiry, timeout_output, sys_reset_pulse;
  logic                  expired_cond, waiting;
  logic [WAIT_SEL_W-1:0] wait_sel;
  logic [PERIOD_W-1:0]   timeout_period, count_value;
  logic [3:0]            exp_q[$];
  int                    n_errors, checks_done, k;
  event                  smp;
  logic [3:0]            seen_flags;

  assign seen_flags = {expired_cond, timeout_output, waiting, sys_reset_pulse};

  wdsup_watchdog wdsup_watchdog_i (.*);
  wdsup_host wdsup_host_i (.*);

  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    $display("Counts: checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Single comparison point; a difference prints both values in hex.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Oldest note is compared with {expired, pin, waiting, pulse} seen now.
  // No tick falls inside the run, so the count must still read its reset value.
  always @(smp) begin
    check({4'h0, seen_flags}, {4'h0, exp_q[0]});
    check(count_value, COUNT_RST);
    void'(exp_q.pop_front());
  end

  task automatic note(input logic [3:0] e);
    exp_q.push_back(e);
    -> smp;
  endtask

  // Bounded wait for expiry; running out of cycles ends the run.
  task automatic wait_exp;
    for (k = 0; k < 20 && expired_cond !== 1'b1; k++) @(negedge sys_clk);
    if (k == 20) begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic kick(input logic p);
    kpin = p;
    kreq = 1'b1;
    @(negedge sys_clk);
    kreq = 1'b0;
    @(negedge sys_clk);
  endtask

  // Zero period makes every expiry reachable within a few cycles.
  initial begin
    {enable, kick_pin_en, timeout_pin_en, reset_on_expiry, kreq, kpin} = 6'h00;
    wait_sel = 4'h0;
    timeout_period = 8'h00;
    rstn = 1'b0;
    void'($urandom(24));
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    {kick_pin_en, timeout_pin_en, enable} = 3'h7;
    for (int m = 0; m < 2; m++) begin
      wait_exp();
      note(4'hC);
      kick(m[0]);
      note(4'h0);
    end
    kick_pin_en = 1'b0;
    wait_exp();
    kick(1'b1);
    note(4'hC);
    $display("Test pin mode done");
    enable = 1'b0;
    timeout_pin_en = 1'b0;
    @(negedge sys_clk);
    enable = 1'b1;
    wait_exp();
    note(4'h8);
    timeout_pin_en = 1'b1;
    enable = 1'b0;
    reset_on_expiry = 1'b1;
    @(negedge sys_clk);
    note(4'h0);
    enable = 1'b1;
    wait_exp();
    note(4'h9);
    @(negedge sys_clk);
    note(4'h8);
    $display("Test reset mode done");
    enable = 1'b0;
    kick_pin_en = 1'b1;
    wait_sel = 4'($urandom_range(15, 1));
    @(negedge sys_clk);
    enable = 1'b1;
    repeat (3) @(negedge sys_clk);
    kick(1'($urandom_range(1, 0)));
    note(4'h2);
    $display("Test initial wait done");
    @(negedge sys_clk);
    conclude();
  end
endmodule

// *** bench/wdsup_host.sv ***
// Host model that kicks the supervision timer by pin or by command.
`timescale 1ns/10ps
module wdsup_host (
  input  wire logic sys_clk,
  input  wire logic kreq,
  input  wire logic kpin,
  output logic      kick_input,
  output logic      kick_cmd
);
  initial {kick_input, kick_cmd} = 2'h0;
  // Changes land just after the edge, so the timer never sees a half-made kick.
  always @(posedge sys_clk) begin
    kick_cmd <= kreq & ~kpin;
    if (kreq & kpin) kick_input <= ~kick_input;
  end
endmodule

// *** bench/wdsup_watchdog_asserts.sv ***
// Checker of port timing for the supervision timer.
`timescale 1ns/10ps
module wdsup_chk
  import wdsup_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                enable,
  input wire logic                kick_pin_en,
  input wire logic                kick_input,
  input wire logic                kick_cmd,
  input wire logic [PERIOD_W-1:0] timeout_period,
  input wire logic                timeout_pin_en,
  input wire logic                reset_on_expiry,
  input wire logic                timeout_output,
  input wire logic                sys_reset_pulse,
  input wire logic                expired_cond,
  input wire logic                waiting,
  input wire logic [PERIOD_W-1:0] count_value
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Expiry, kicks and modes, all in the one clock domain.
  a_pulse_one_cycle: assert property (sys_reset_pulse |=> !sys_reset_pulse)
    else $error("reset pulse longer than one cycle");
  a_pulse_on_rise: assert property (sys_reset_pulse |-> $rose(expired_cond) && $past(reset_on_expiry))
    else $error("reset pulse without fresh expiry");
  a_pin_mode_only: assert property (timeout_output |-> expired_cond && $past(timeout_pin_en && !reset_on_expiry))
    else $error("timeout pin outside pin mode");
  a_disable_clears: assert property (!enable |=> !expired_cond && !waiting)
    else $error("disable left timer active");
  a_cmd_kick_clears: assert property (enable && kick_cmd && !waiting |=> !expired_cond && count_value == 8'h00)
    else $error("command kick did not restart");
  a_pin_kick_clears: assert property (enable && kick_pin_en && !waiting && $changed(kick_input) |=> !expired_cond)
    else $error("pin edge did not restart");
  a_exp_needs_count: assert property ($rose(expired_cond) |-> $past(count_value) >= $past(timeout_period))
    else $error("expiry before period ran out");
  a_wait_no_expiry: assert property (waiting |-> !expired_cond && !timeout_output)
    else $error("expiry during initial wait");
  c_pulse: cover property (sys_reset_pulse);
  c_wait: cover property ($rose(waiting));
  c_kick: cover property ($fell(expired_cond));
  c_pin: cover property ($rose(timeout_output));
endmodule

bind wdsup_watchdog wdsup_chk wdsup_chk_i (.*);

// *** pkg/wdsup_pkg.sv ***
// Package with constants and types for the supervision timer block.
package wdsup_pkg;

  // Clock rate and the two time bases used by the timer.
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned WAIT_BASE_MS    = 100;
  localparam int unsigned WAIT_BASE_TICKS = WAIT_BASE_MS / TICK_MS;

  // Field widths and reset values.
  localparam int unsigned TICK_W      = 19;
  localparam int unsigned PERIOD_W    = 8;
  localparam int unsigned WAIT_SEL_W  = 4;
  localparam int unsigned WAIT_W      = 18;
  localparam int unsigned PULSE_TICKS = 1;
  localparam logic [TICK_W-1:0]   TICK_RST  = 19'h00000;
  localparam logic [WAIT_W-1:0]   WAIT_RST  = 18'h00000;
  localparam logic [PERIOD_W-1:0] COUNT_RST = 8'h00;

  // Timer phases.
  typedef enum logic [1:0] {
    WDSUP_IDLE,
    WDSUP_WAIT,
    WDSUP_RUN,
    WDSUP_EXPIRED
  } wdsup_state_t;

endpackage

// *** rtl/wdsup_tick.sv ***
// Divider that produces a one-cycle enable every 10 ms.
`timescale 1ns/10ps
module wdsup_tick
  import wdsup_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  output logic      tick_en
);

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              pulse;
  } wdsup_tick_st_t;

  wdsup_tick_st_t st_reg;
  wdsup_tick_st_t st_next;

  // Free-running counter; the pulse is registered so it is glitch-free.
  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    if (st_reg.cnt == TICK_W'(TICK_CYCLES - 1)) begin
      st_next.cnt = TICK_RST;
      st_next.pulse = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_en = st_reg.pulse;

endmodule

// *** rtl/wdsup_watchdog.sv ***
// Supervision timer with initial wait, time-out counted in 10 ms ticks and expiry outputs.
`timescale 1ns/10ps

module wdsup_watchdog
  import wdsup_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  enable,
  input  wire logic                  kick_pin_en,
  input  wire logic                  kick_input,
  input  wire logic                  kick_cmd,
  input  wire logic [WAIT_SEL_W-1:0] wait_sel,
  input  wire logic [PERIOD_W-1:0]   timeout_period,
  input  wire logic                  timeout_pin_en,
  input  wire logic                  reset_on_expiry,
  output logic                       timeout_output,
  output logic                       sys_reset_pulse,
  output logic                       expired_cond,
  output logic                       waiting,
  output logic [PERIOD_W-1:0]        count_value
);

  typedef struct packed {
    wdsup_state_t        state;
    logic                kick_prev;
    logic                kick_seen;
    logic [WAIT_W-1:0]   wait_cnt;
    logic [PERIOD_W-1:0] count;
    logic                to_out;
    logic                rst_pulse;
    logic                expired;
    logic                waiting;
  } wdsup_st_t;

  wdsup_st_t   st_reg;
  wdsup_st_t   st_next;
  logic        tick_en;
  logic        pin_edge;
  logic        kick;
  logic [WAIT_W-1:0] wait_ticks;
  logic              wait_last;
  logic              period_done;

  // How the phases fit together.
  // The timer sits in the idle phase while enable is low, with every output except the count cleared.
  // Raising enable starts either the initial wait or the running phase at once.
  // The initial wait counts whole 10 ms ticks until the selected length is reached.
  // Kicks are ignored during the wait, so boot code cannot cut it short.
  // The running phase counts 10 ms ticks and compares the count with the period.
  // A kick in the running phase clears the count and keeps the timer alive.
  // When the count reaches the period with no kick, the timer expires.
  // The expired phase is latched and only a kick brings the timer back to running.
  // Dropping enable in any phase returns the timer to idle on the next edge.
  //
  // Limitations that a user must know.
  // The tick divider runs free and is not aligned to enable, so every interval
  // may be up to one tick shorter than its nominal length.
  // A period of zero expires on the first edge after entering the running phase.
  // The period input is sampled live, so lowering it while running can expire early.
  // The wait select is read at enable and during the wait, not latched once.
  //
  // Output modes.
  // In pin mode the time-out output follows the expired level.
  // In reset mode a one-cycle pulse is issued instead and the pin stays low,
  // so one expiry never reaches the reset logic by two paths at once.
  // The expired level is offered in every mode to the reset condition logic.
  //
  // Kick sources.
  // A command kick is a one-cycle pulse and is taken on the edge where it is high.
  // A pin kick is any change of level, compared with the level one edge before.
  // The first sample after reset is only stored, never taken as an edge.

  // Shared 10 ms time base.
  wdsup_tick u_tick (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .tick_en (tick_en)
  );

  // Wait length in ticks: zero for select 0, else 100 ms shifted left by select minus one.
  always_comb begin
    if (wait_sel == 4'h0) begin
      wait_ticks = WAIT_RST;
    end else begin
      wait_ticks = WAIT_W'(WAIT_BASE_TICKS) << (wait_sel - 4'h1);
    end
  end

  // Any edge on the kick pin counts, but only when the pin is assigned the kick role.
  assign pin_edge = kick_pin_en && st_reg.kick_seen
                    && (kick_input != st_reg.kick_prev);
  assign kick     = pin_edge || kick_cmd;

  // Last tick of the initial wait; the wait counter is compared before it steps.
  // The counter never exceeds the longest wait, so the sum cannot wrap.
  assign wait_last = tick_en && (st_reg.wait_cnt + 1'b1 >= wait_ticks);

  // Period used up; compared before the increment so a kick on the same
  // edge still wins and no expiry is reported.
  assign period_done = (st_reg.count >= timeout_period);

  // Main sequencer; the reset pulse lasts one cycle so it cannot retrigger itself.
  always_comb begin
    st_next = st_reg;
    st_next.kick_prev = kick_input;
    st_next.kick_seen = 1'b1; // The first sample after reset is never taken as an edge.
    st_next.rst_pulse = 1'b0;
    case (st_reg.state)
      WDSUP_IDLE: begin
        // Counters are cleared on the way out of idle, not while idle,
        // so the last count stays visible after the timer is disabled.
        st_next.to_out = 1'b0;
        st_next.expired = 1'b0;
        if (enable) begin
          st_next.wait_cnt = WAIT_RST;
          st_next.count = COUNT_RST;
          if (wait_ticks == WAIT_RST) begin
            st_next.state = WDSUP_RUN;
          end else begin
            st_next.state = WDSUP_WAIT;
          end
        end
      end
      WDSUP_WAIT: begin
        // Kicks are dropped here so that boot code cannot shorten the wait.
        if (tick_en) begin
          if (wait_last) begin
            st_next.state = WDSUP_RUN;
            st_next.count = COUNT_RST;
          end else begin
            st_next.wait_cnt = st_reg.wait_cnt + 1'b1;
          end
        end
      end
      WDSUP_RUN: begin
        // Priority is kick first, then expiry, then the tick step.
        // Putting the kick first means a late but valid kick is never lost.
        if (kick) begin
          st_next.count = COUNT_RST;
        end else if (period_done) begin
          st_next.state = WDSUP_EXPIRED;
          st_next.expired = 1'b1;
          st_next.to_out = timeout_pin_en && !reset_on_expiry;
          st_next.rst_pulse = reset_on_expiry;
        end else if (tick_en) begin
          st_next.count = st_reg.count + 1'b1;
        end
      end
      WDSUP_EXPIRED: begin
        // Latched until a kick; the count does not restart on its own.
        if (kick) begin
          st_next.state = WDSUP_RUN;
          st_next.count = COUNT_RST;
          st_next.expired = 1'b0;
          st_next.to_out = 1'b0;
        end
      end
      default: begin
        st_next.state = WDSUP_IDLE;
      end
    endcase
    if (!enable) begin
      st_next.state = WDSUP_IDLE;
      st_next.to_out = 1'b0;
      st_next.expired = 1'b0;
      st_next.rst_pulse = 1'b0;
    end
    // The wait flag is a flip-flop of its own so the output is not a decode.
    st_next.waiting = (st_next.state == WDSUP_WAIT);
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // All outputs come straight from state flip-flops.
  assign timeout_output  = st_reg.to_out;
  assign sys_reset_pulse = st_reg.rst_pulse;
  assign expired_cond    = st_reg.expired;
  assign waiting         = st_reg.waiting;
  assign count_value     = st_reg.count;

endmodule
